// ---- core/ccsirq_top.sv ----
// ccsirq_top: identity, readiness, sticky status, enables and interrupt line.
// assumes a byte register port (addr, wdata, write and read strobes) on mclk_in;
// monitor event inputs are asynchronous levels from the reference and loop logic.
`timescale 1ns/10ps
module ccsirq_top #(
  parameter int INIT_LOW_CYCLES = ccsirq_pkg::INIT_LOW_CYCLES,
  parameter int READY_CYCLES = ccsirq_pkg::READY_MAX_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic ref_fail_in,
  input wire logic holdover_in,
  input wire logic loop_unlock_flag_in,
  output logic [7:0] reg_rdata_out,
  output logic irq_out,
  output logic ready_out
);
  // ---------------------------------------------------------------
  // event synchronisers
  // ---------------------------------------------------------------
  logic ref_fail_s;
  logic holdover_s;
  logic unlock_s;
  logic ref_fail_d_reg;
  logic holdover_d_reg;
  logic unlock_d_reg;

  ccsirq_sync u_ref (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(ref_fail_in),
    .level_out(ref_fail_s)
  );
  ccsirq_sync u_hold (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(holdover_in),
    .level_out(holdover_s)
  );
  ccsirq_sync u_unlock (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(loop_unlock_flag_in),
    .level_out(unlock_s)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic [7:0] ref_status_reg;
  logic [7:0] loop_status_reg;
  logic [7:0] ref_enable_reg;
  logic [7:0] loop_enable_reg;
  logic [ccsirq_pkg::CNT_W-1:0] init_cnt_reg;
  logic ready_reg;

  wire wr_ref_en = reg_wr_in && hit(reg_addr_in, ccsirq_pkg::ADDR_REF_ENABLE);
  wire wr_loop_en = reg_wr_in && hit(reg_addr_in, ccsirq_pkg::ADDR_LOOP_ENABLE);
  // host clears sticky bits by writing one to them
  wire wr_ref_st = reg_wr_in && hit(reg_addr_in, ccsirq_pkg::ADDR_REF_STATUS);
  wire wr_loop_st = reg_wr_in && hit(reg_addr_in, ccsirq_pkg::ADDR_LOOP_STATUS);

  // rising edge of a monitor level counts as one event
  wire ref_evt = ref_fail_s && !ref_fail_d_reg;
  wire hold_evt = holdover_s && !holdover_d_reg;
  wire unlock_evt = unlock_s && !unlock_d_reg;

  wire ref_set = ref_evt && ref_enable_reg[ccsirq_pkg::REF_FAULT_BIT];
  wire hold_set = hold_evt && loop_enable_reg[ccsirq_pkg::HOLDOVER_BIT];
  wire unlock_set = unlock_evt && loop_enable_reg[ccsirq_pkg::UNLOCK_BIT];

  wire [7:0] ref_clr = wr_ref_st ? reg_wdata_in : 8'h00;
  wire [7:0] loop_clr = wr_loop_st ? reg_wdata_in : 8'h00;
  wire [7:0] ref_set_v = {7'h00, ref_set};
  wire [7:0] loop_set_v = {6'h00, unlock_set, hold_set};
  // set wins over a clear in the same cycle
  wire [7:0] ref_status_next = (ref_status_reg & ~ref_clr) | ref_set_v;
  wire [7:0] loop_status_next = (loop_status_reg & ~loop_clr) | loop_set_v;

  wire irq_next = (|ref_status_next) || (|loop_status_next);

  // ---------------------------------------------------------------
  // readiness sequencing
  // ---------------------------------------------------------------
  // the undefined window after reset also reads low, so two phases suffice
  typedef enum logic [1:0] {
    CCSIRQ_COUNTING = 2'b01,
    CCSIRQ_READY = 2'b10
  } ccsirq_rdy_t;

  ccsirq_rdy_t rdy_state_reg;
  ccsirq_rdy_t rdy_state_next;

  // last count before ready: flag is up after READY_CYCLES edges, not one later
  localparam int READY_LAST = READY_CYCLES - 1;

  wire cnt_run = (rdy_state_reg == CCSIRQ_COUNTING);
  wire cnt_done = (init_cnt_reg == READY_LAST[ccsirq_pkg::CNT_W-1:0]);

  always_comb
  begin
    rdy_state_next = rdy_state_reg;
    case (rdy_state_reg)
      CCSIRQ_COUNTING:
        if (cnt_done)
          rdy_state_next = CCSIRQ_READY;
      CCSIRQ_READY:
        rdy_state_next = CCSIRQ_READY;
      default:
        rdy_state_next = CCSIRQ_COUNTING;
    endcase
  end

  // ready forced low through the init window, then held until reset
  wire ready_next = (rdy_state_next == CCSIRQ_READY);
  wire [7:0] ident_word = {ready_reg, ccsirq_pkg::DEVICE_REVISION,
                           ccsirq_pkg::DEVICE_IDENT_FIELD};

  // ---------------------------------------------------------------
  // read selection
  // ---------------------------------------------------------------
  // unmapped offsets read as zero; rdata holds between reads
  wire [7:0] rdata_next =
    !reg_rd_in ? reg_rdata_out :
    hit(reg_addr_in, ccsirq_pkg::ADDR_IDENT) ? ident_word :
    hit(reg_addr_in, ccsirq_pkg::ADDR_REF_STATUS) ? ref_status_reg :
    hit(reg_addr_in, ccsirq_pkg::ADDR_LOOP_STATUS) ? loop_status_reg :
    hit(reg_addr_in, ccsirq_pkg::ADDR_REF_ENABLE) ? ref_enable_reg :
    hit(reg_addr_in, ccsirq_pkg::ADDR_LOOP_ENABLE) ? loop_enable_reg : 8'h00;

  // ---------------------------------------------------------------
  // edge detectors
  // ---------------------------------------------------------------
  // delayed copies reset to the idle level, so reset makes no false event
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ref_fail_d_reg <= 1'b0;
      holdover_d_reg <= 1'b0;
      unlock_d_reg <= 1'b0;
    end
    else
    begin
      ref_fail_d_reg <= ref_fail_s;
      holdover_d_reg <= holdover_s;
      unlock_d_reg <= unlock_s;
    end
  end

  // ---------------------------------------------------------------
  // sticky status
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ref_status_reg <= ccsirq_pkg::STATUS_RESET;
      loop_status_reg <= ccsirq_pkg::STATUS_RESET;
    end
    else
    begin
      ref_status_reg <= ref_status_next;
      loop_status_reg <= loop_status_next;
    end
  end

  // ---------------------------------------------------------------
  // enables
  // ---------------------------------------------------------------
  // reserved bits are kept as written; only the low bits gate events
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ref_enable_reg <= ccsirq_pkg::ENABLE_RESET;
      loop_enable_reg <= ccsirq_pkg::ENABLE_RESET;
    end
    else
    begin
      if (wr_ref_en)
        ref_enable_reg <= reg_wdata_in;
      if (wr_loop_en)
        loop_enable_reg <= reg_wdata_in;
    end
  end

  // ---------------------------------------------------------------
  // readiness counter
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      init_cnt_reg <= '0;
      rdy_state_reg <= CCSIRQ_COUNTING;
      ready_reg <= 1'b0;
    end
    else
    begin
      if (cnt_run)
        init_cnt_reg <= init_cnt_reg + 1'b1;
      rdy_state_reg <= rdy_state_next;
      ready_reg <= ready_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // ready level mirrors the register bit for a host polling pin
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      irq_out <= 1'b0;
      reg_rdata_out <= 8'h00;
      ready_out <= 1'b0;
    end
    else
    begin
      irq_out <= irq_next;
      reg_rdata_out <= rdata_next;
      ready_out <= ready_next;
    end
  end
endmodule : ccsirq_top

// ---- pkg/ccsirq_pkg.sv ----
// ccsirq_pkg: constants for the clock chip status and interrupt block.
// assumes a 50 MHz mclk_in and a byte-wide register port decoded elsewhere.
//
// Behaviour
// - identity register low five bits: device code
// - bits 6:5 report revision; zero means elsewhere
// - ready bit reads low after reset window
// - ready bit rises within 55 ms
// - reference failure sets fault status bit 0
// - fault status set only when enabled
// - any set status bit raises interrupt line
// - holdover entry sets loop status bit 0
// - loss of lock sets loop status bit 1
// - fault enable low: no record, no interrupt
// - holdover enable low: no record, no interrupt
// - unlock enable bit 1 gates unlock bit
package ccsirq_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_IDENT = 8'h00;
  localparam logic [7:0] ADDR_REF_STATUS = 8'h02;
  localparam logic [7:0] ADDR_LOOP_STATUS = 8'h03;
  localparam logic [7:0] ADDR_REF_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_LOOP_ENABLE = 8'h05;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int IDENT_CODE_LSB = 0;
  localparam int IDENT_REV_LSB = 5;
  localparam int IDENT_READY_BIT = 7;
  localparam int REF_FAULT_BIT = 0;
  localparam int HOLDOVER_BIT = 0;
  localparam int UNLOCK_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  // arbitrary identity values, not tied to any real part
  localparam logic [4:0] DEVICE_IDENT_FIELD = 5'h15;
  localparam logic [1:0] DEVICE_REVISION = 2'h1;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int INIT_LOW_MS = 45;
  localparam int READY_MAX_MS = 55;
  // least time: ready stays low at least 45 ms
  localparam int INIT_LOW_CYCLES = (INIT_LOW_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ready rises no later than 55 ms; rounded down
  localparam int READY_MAX_CYCLES = (READY_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int CNT_W = 22;
endpackage : ccsirq_pkg

// ---- core/ccsirq_sync.sv ----
// ccsirq_sync: three-stage synchroniser with agreement filter for event pins.
// assumes asynchronous inputs; output changes only when stages 2 and 3 agree.
`timescale 1ns/10ps
module ccsirq_sync (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        level_out <= s3_reg;
    end
  end
endmodule : ccsirq_sync

// ---- verif/ccsirq_properties.sv ----
// ccsirq_properties: port assertions.
// assumes the bind hands on READY_CYCLES.
`timescale 1ns/10ps
module ccsirq_properties #(
  parameter int READY_CYCLES = 50
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic irq_out,
  input wire logic ready_out
);
  wire logic rd0 = reg_rd_in && reg_addr_in == 8'h00;
  wire logic rds = reg_rd_in && reg_addr_in[7:1] == 7'h01;
  int cnt_reg;
  // saturates so the count cannot wrap
  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
      cnt_reg <= 0;
    else if (cnt_reg < READY_CYCLES + 4)
      cnt_reg <= cnt_reg + 1;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  ident_code_a: assert property (rd0 |=> reg_rdata_out[4:0] == ccsirq_pkg::DEVICE_IDENT_FIELD)
    else $error("ident");
  ident_rev_a: assert property (rd0 |=> reg_rdata_out[6:5] == ccsirq_pkg::DEVICE_REVISION)
    else $error("revision");
  ready_early_a: assert property (ready_out |-> cnt_reg >= READY_CYCLES)
    else $error("early ready");
  ready_late_a: assert property (!ready_out |-> cnt_reg < READY_CYCLES)
    else $error("late ready");
  status_rsvd_a: assert property (rds |=> reg_rdata_out[7:2] == 6'h00)
    else $error("reserved bits");
  ref_rsvd_a: assert property (rds && !reg_addr_in[0] |=> reg_rdata_out[1] == 1'b0)
    else $error("ref status");
  irq_status_a: assert property (rds ##1 reg_rdata_out != 8'h00 |-> $past(irq_out))
    else $error("irq missing");
  irq_clear_a: assert property ($fell(irq_out) && $past(rst_n_in) |-> $past(reg_wr_in))
    else $error("irq fell");
endmodule : ccsirq_properties
bind ccsirq_top ccsirq_properties #(.READY_CYCLES(READY_CYCLES)) i_ccsirq_properties (.mclk_in,
  .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out, .ready_out);

// ---- verif/ccsirq_host.sv ----
// ccsirq_host: host side of the register port.
// assumes the caller samples read data when acc returns.
`timescale 1ns/10ps
module ccsirq_host (
  input wire logic mclk_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  initial
    {addr_out, wdata_out, wr_out, rd_out} = 18'h00000;
  // released address and data inverted, strobes dropped, so stale values cannot pass
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    #1;
    {addr_out, wdata_out, wr_out, rd_out} = {a, d, w, !w};
    @(posedge mclk_in);
    #1;
    {addr_out, wdata_out, wr_out, rd_out} = {~a, ~d, 2'h0};
    @(posedge mclk_in);
    #1;
  endtask : acc
endmodule : ccsirq_host

// ---- verif/ccsirq_top_tb.sv ----
// ccsirq_top_tb: reset case, register rows, then event and mid-reset cases.
// assumes ccsirq_host on the port; ready count cut to 50.
`timescale 1ns/10ps
module ccsirq_top_tb;
  localparam logic [7:0] ID = {1'b1, ccsirq_pkg::DEVICE_REVISION, ccsirq_pkg::DEVICE_IDENT_FIELD};
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] ev = 3'h0;
  wire logic [7:0] a, d, q;
  wire logic wr, rd, irq, rdy;
  int num_errors = 0;
  int total_checks = 0;
  int n = 0;
  // address, write data, read back
  logic [23:0] rows [8] = '{24'h04FFFF, 24'h050303, {16'h0000, ID}, 24'h075A00, 24'h02FF00,
    24'h03FF00, 24'h040000, 24'h050000};
  always #10 mclk_in = ~mclk_in;
  ccsirq_host i_ccsirq_host (.mclk_in, .addr_out(a), .wdata_out(d), .wr_out(wr), .rd_out(rd));
  ccsirq_top #(.READY_CYCLES(50)) i_ccsirq_top (.mclk_in, .rst_n_in, .reg_addr_in(a),
    .reg_wdata_in(d), .reg_wr_in(wr), .reg_rd_in(rd), .ref_fail_in(ev[0]), .holdover_in(ev[1]),
    .loop_unlock_flag_in(ev[2]), .reg_rdata_out(q), .irq_out(irq), .ready_out(rdy));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] x, input logic [7:0] e);
    i_ccsirq_host.acc(1'b0, x, 8'h00);
    chk(q, e);
  endtask : rdc
  task automatic wr8(input logic [7:0] x, input logic [7:0] v);
    i_ccsirq_host.acc(1'b1, x, v);
  endtask : wr8
  task automatic pulse(input logic [2:0] p);
    ev = p;
    #240;
    ev = 3'h0;
    #240;
  endtask : pulse
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    #100000;
    num_errors++;
    test_done();
  end
  initial
  begin
    repeat (20) @(posedge mclk_in);
    chk({6'h00, irq, rdy}, 8'h00);
    #1;
    rst_n_in = 1'b1;
    rdc(8'h00, {1'b0, ID[6:0]});
    while (rdy !== 1'b1 && n < 60)
    begin
      #20;
      n++;
    end
    chk({7'h00, n < 50}, 8'h01);
    $display("reset test done");
    foreach (rows[i])
    begin
      wr8(rows[i][23:16], rows[i][15:8]);
      rdc(rows[i][23:16], rows[i][7:0]);
    end
    $display("register rows done");
    pulse(3'h7);
    rdc(8'h02, 8'h00);
    rdc(8'h03, 8'h00);
    wr8(8'h04, 8'h01);
    wr8(8'h05, 8'h01);
    pulse(3'h7);
    chk({7'h00, irq}, 8'h01);
    rdc(8'h02, 8'h01);
    rdc(8'h03, 8'h01);
    wr8(8'h02, 8'h01);
    wr8(8'h03, 8'h01);
    wr8(8'h05, 8'h02);
    pulse(3'h6);
    rdc(8'h03, 8'h02);
    wr8(8'h03, 8'h02);
    wr8(8'h05, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("event test done");
    wr8(8'h04, 8'h01);
    pulse(3'h1);
    chk({7'h00, irq}, 8'h01);
    rst_n_in = 1'b0;
    @(posedge mclk_in);
    #1;
    chk({6'h00, irq, rdy}, 8'h00);
    rst_n_in = 1'b1;
    rdc(8'h02, 8'h00);
    rdc(8'h04, 8'h00);
    rdc(8'h00, {1'b0, ID[6:0]});
    $display("mid reset test done");
    test_done();
  end
endmodule : ccsirq_top_tb
